//--- rtl/sccfp_pkg.sv
package sccfp_pkg;
  localparam int POOL_DEPTH = 32;
  localparam int CNT_W = 6;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // register offsets
  localparam logic [ADDR_W-1:0] OFS_TRANSMIT_QUEUE = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_RECEIVE_QUEUE = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_CHANNEL_CONFIG = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_COMMAND = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_INTERRUPT_STATUS_ONE = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_FILL_LEVEL = 4'h5;

  // channel config fields
  localparam int CFG_POWER_UP_BIT = 0;
  localparam int CFG_BIG_ENDIAN_BIT = 1;
  localparam int CFG_THRESHOLD_LSB = 2;
  localparam logic [3:0] CFG_RESET = 4'hC;

  // command fields
  localparam int CMD_RECEIVER_FLUSH_BIT = 0;

  // interrupt status fields
  localparam int STAT_UNDERRUN_BIT = 0;
  localparam int STAT_OVERFLOW_BIT = 1;
  localparam int STAT_FRAME_LOST_BIT = 2;
  localparam int STAT_END_PENDING_BIT = 3;
  localparam int STAT_TX_BLOCKED_BIT = 4;

  // overflow mark inside the receive status byte
  localparam int RSB_OVERFLOW_BIT = 5;

  // fill level register field
  localparam int LEVEL_RX_LSB = 8;

  typedef enum logic [1:0] {
    RX_STORE = 2'b01,
    RX_DROP = 2'b10
  } sccfp_rx_e;

  function automatic logic [CNT_W-1:0] sccfp_threshold(input logic [1:0] sel);
    case (sel)
      2'h0: sccfp_threshold = 6'h04;
      2'h1: sccfp_threshold = 6'h08;
      2'h2: sccfp_threshold = 6'h10;
      default: sccfp_threshold = 6'h20;
    endcase
  endfunction : sccfp_threshold
endpackage : sccfp_pkg

//--- rtl/sccfp_queue.sv
// byte queue taking and giving up to two entries a cycle; depth must be a power of two
module sccfp_queue #(
  parameter int W = 8,
  parameter int DEPTH = 32,
  parameter int CW = $clog2(DEPTH + 1)
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic flush_in,
  input wire logic [1:0] push_n_in,
  input wire logic [2*W-1:0] push_data_in,
  input wire logic [1:0] pop_n_in,
  output logic [W-1:0] head0_out,
  output logic [W-1:0] head1_out,
  output logic [CW-1:0] count_out
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] wr_next;
  logic [AW-1:0] rd_reg;
  logic [AW-1:0] rd_next;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;

  always_comb begin
    wr_next = wr_reg + AW'(push_n_in);
    rd_next = rd_reg + AW'(pop_n_in);
    cnt_next = cnt_reg + CW'(push_n_in) - CW'(pop_n_in);
    if (flush_in) begin
      wr_next = '0;
      rd_next = '0;
      cnt_next = '0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else if (ce_in) begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  // caller guarantees room; a flush drops a same-cycle push
  always_ff @(posedge clk_in) begin
    if (ce_in && !flush_in) begin
      if (push_n_in != 2'h0) begin
        mem[wr_reg] <= push_data_in[W-1:0];
      end
      if (push_n_in == 2'h2) begin
        mem[wr_reg + AW'(1)] <= push_data_in[2*W-1:W];
      end
    end
  end

  assign head0_out = mem[rd_reg];
  assign head1_out = mem[rd_reg + AW'(1)];
  assign count_out = cnt_reg;
endmodule : sccfp_queue

//--- rtl/sccfp_top.sv
module sccfp_top
  import sccfp_pkg::*;
(
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic reg_word_in,
  output logic [DATA_W-1:0] reg_rdata_out,
  input wire logic dma_tx_wr_in,
  input wire logic [7:0] dma_tx_data_in,
  output logic dma_tx_req_out,
  input wire logic dma_rx_rd_in,
  output logic [7:0] dma_rx_data_out,
  output logic dma_rx_req_out,
  input wire logic tx_clk_ok_in,
  input wire logic tx_enable_in,
  input wire logic tx_take_in,
  output logic tx_valid_out,
  output logic [7:0] tx_byte_out,
  input wire logic transmit_underrun_in,
  output logic tx_blocked_out,
  input wire logic rx_valid_in,
  input wire logic rx_end_in,
  input wire logic rx_abort_in,
  input wire logic [7:0] rx_byte_in,
  output logic rx_data_req_out,
  output logic receive_frame_lost_out
);
  logic [CNT_W-1:0] txh_cnt, txs_cnt, rxs_cnt, rxh_cnt;
  logic [7:0] txh_h0, txs_h0, rxs_h0, rxh_h0, rxh_h1;
  logic [1:0] txh_push, txh_pop, txs_push, txs_pop, rxs_push, rxs_pop, rxh_push, rxh_pop;
  logic [15:0] txh_data, rxs_data;

  logic [3:0] cfg_reg, cfg_next;
  logic blocked_reg, blocked_next;
  logic underrun_reg, underrun_next, overflow_reg, overflow_next, lost_reg, lost_next;
  logic end_pend_reg, end_pend_next, stored_reg, stored_next, lost_pulse_reg, lost_pulse_next;
  sccfp_rx_e rx_state_reg, rx_state_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic [7:0] dma_rdata_reg, dma_rdata_next;

  logic cpu_wr_tx, cpu_rd_rx, stat_rd, flush, power_up, big_endian, move_tx, rx_space;
  logic [1:0] cpu_n;
  logic [CNT_W-1:0] threshold;

  assign power_up = cfg_reg[CFG_POWER_UP_BIT];
  assign big_endian = cfg_reg[CFG_BIG_ENDIAN_BIT];
  assign threshold = sccfp_threshold(cfg_reg[CFG_THRESHOLD_LSB +: 2]);
  assign cpu_wr_tx = reg_wr_in && reg_addr_in == OFS_TRANSMIT_QUEUE;
  assign cpu_rd_rx = reg_rd_in && reg_addr_in == OFS_RECEIVE_QUEUE;
  assign stat_rd = reg_rd_in && reg_addr_in == OFS_INTERRUPT_STATUS_ONE;
  assign flush = reg_wr_in && reg_addr_in == OFS_COMMAND && reg_wdata_in[CMD_RECEIVER_FLUSH_BIT];
  assign cpu_n = reg_word_in ? 2'h2 : 2'h1;

  // transmit path
  always_comb begin
    txh_push = 2'h0;
    txh_data = {8'h00, dma_tx_data_in};
    // refusal is silent: a blocked or overfull write is dropped
    if (cpu_wr_tx) begin
      if (!blocked_reg && CNT_W'(POOL_DEPTH) - txh_cnt >= CNT_W'(cpu_n)) begin
        txh_push = cpu_n;
      end
      if (!reg_word_in) begin
        txh_data = {8'h00, reg_wdata_in[7:0]};
      end else if (big_endian) begin
        txh_data = {reg_wdata_in[7:0], reg_wdata_in[15:8]};
      end else begin
        txh_data = reg_wdata_in;
      end
    end else if (dma_tx_wr_in && !blocked_reg && txh_cnt != CNT_W'(POOL_DEPTH)) begin
      txh_push = 2'h1;
    end
  end

  // cpu has priority over dma on the same cycle
  assign move_tx = power_up && tx_clk_ok_in && !blocked_reg && txh_cnt != '0
                   && txs_cnt != CNT_W'(POOL_DEPTH);
  assign txh_pop = {1'b0, move_tx};
  assign txs_push = {1'b0, move_tx};
  assign tx_valid_out = txs_cnt != '0 && tx_enable_in && !blocked_reg;
  assign txs_pop = {1'b0, tx_valid_out && tx_take_in};
  assign tx_byte_out = txs_h0;
  assign dma_tx_req_out = !blocked_reg && txh_cnt != CNT_W'(POOL_DEPTH);
  assign tx_blocked_out = blocked_reg;

  // host pool then shadow pool on transmit; shadow pool then host pool on receive
  sccfp_queue #(.W(8), .DEPTH(POOL_DEPTH), .CW(CNT_W)) u_tx_host (
    .clk_in(mclk_in), .rst_in(sys_rst_in), .ce_in(ce_in), .flush_in(1'b0),
    .push_n_in(txh_push), .push_data_in(txh_data), .pop_n_in(txh_pop),
    .head0_out(txh_h0), .head1_out(), .count_out(txh_cnt));
  sccfp_queue #(.W(8), .DEPTH(POOL_DEPTH), .CW(CNT_W)) u_tx_shadow (
    .clk_in(mclk_in), .rst_in(sys_rst_in), .ce_in(ce_in), .flush_in(1'b0),
    .push_n_in(txs_push), .push_data_in({8'h00, txh_h0}), .pop_n_in(txs_pop),
    .head0_out(txs_h0), .head1_out(), .count_out(txs_cnt));

  // receive path
  assign rx_space = rxs_cnt != CNT_W'(POOL_DEPTH);

  always_comb begin
    rx_state_next = rx_state_reg;
    stored_next = stored_reg;
    rxs_push = 2'h0;
    rxs_data = {8'h00, rx_byte_in};
    overflow_next = overflow_reg && !stat_rd;
    lost_next = lost_reg && !stat_rd;
    lost_pulse_next = 1'b0;
    unique case (rx_state_reg)
      RX_STORE: begin
        if (rx_valid_in || rx_end_in) begin
          if (rx_space) begin
            rxs_push = 2'h1;
            stored_next = rx_valid_in; // a pushed end byte closes the frame
          end else begin
            rx_state_next = RX_DROP;
            overflow_next = 1'b1;
          end
        end else if (rx_abort_in) begin
          stored_next = 1'b0;
        end
      end
      RX_DROP: begin
        if (rx_end_in || rx_abort_in) begin
          if (!stored_reg) begin
            lost_pulse_next = 1'b1;
            lost_next = 1'b1;
          end
          if (rx_space) begin
            rx_state_next = RX_STORE;
            if (stored_reg) begin
              rxs_push = 2'h1;
              rxs_data = {8'h00, rx_byte_in | 8'(1 << RSB_OVERFLOW_BIT)};
            end
          end
          stored_next = 1'b0;
        end
      end
    endcase
  end

  // shadow drains into host pool one byte a cycle
  assign rxs_pop = {1'b0, rxs_cnt != '0 && rxh_cnt != CNT_W'(POOL_DEPTH)};
  assign rxh_push = rxs_pop;

  always_comb begin
    rxh_pop = 2'h0;
    if (cpu_rd_rx) begin
      rxh_pop = (reg_word_in && rxh_cnt >= CNT_W'(2)) ? 2'h2 : {1'b0, rxh_cnt != '0};
    end else if (dma_rx_rd_in && rxh_cnt != '0) begin
      rxh_pop = 2'h1;
    end
  end

  sccfp_queue #(.W(8), .DEPTH(POOL_DEPTH), .CW(CNT_W)) u_rx_shadow (
    .clk_in(mclk_in), .rst_in(sys_rst_in), .ce_in(ce_in), .flush_in(flush),
    .push_n_in(rxs_push), .push_data_in(rxs_data), .pop_n_in(rxs_pop),
    .head0_out(rxs_h0), .head1_out(), .count_out(rxs_cnt));
  sccfp_queue #(.W(8), .DEPTH(POOL_DEPTH), .CW(CNT_W)) u_rx_host (
    .clk_in(mclk_in), .rst_in(sys_rst_in), .ce_in(ce_in), .flush_in(flush),
    .push_n_in(rxh_push), .push_data_in({8'h00, rxs_h0}), .pop_n_in(rxh_pop),
    .head0_out(rxh_h0), .head1_out(rxh_h1), .count_out(rxh_cnt));

  assign rx_data_req_out = rxh_cnt >= threshold || end_pend_reg;
  assign dma_rx_req_out = rxh_cnt != '0;
  assign receive_frame_lost_out = lost_pulse_reg;
  assign reg_rdata_out = rdata_reg;
  assign dma_rx_data_out = dma_rdata_reg;

  // registers and status
  always_comb begin
    cfg_next = cfg_reg;
    if (reg_wr_in && reg_addr_in == OFS_CHANNEL_CONFIG) begin
      cfg_next = reg_wdata_in[3:0];
    end
    // the underrun event wins over a same-cycle status read
    blocked_next = (blocked_reg && !stat_rd) || transmit_underrun_in;
    underrun_next = (underrun_reg && !stat_rd) || transmit_underrun_in;
    // frame end mark lives until the pools run dry; flush may kill it early
    end_pend_next = end_pend_reg;
    if (rxh_cnt == '0 && rxs_cnt == '0) begin
      end_pend_next = 1'b0;
    end
    if (flush) begin
      end_pend_next = 1'b0;
    end else if (rxs_push != 2'h0 && rx_end_in) begin
      end_pend_next = 1'b1;
    end
    rdata_next = '0;
    dma_rdata_next = '0;
    if (dma_rx_rd_in && !cpu_rd_rx) begin
      dma_rdata_next = rxh_h0;
    end
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        OFS_RECEIVE_QUEUE: begin
          if (rxh_pop == 2'h2) begin
            rdata_next = big_endian ? {rxh_h0, rxh_h1} : {rxh_h1, rxh_h0};
          end else if (rxh_pop == 2'h1) begin
            rdata_next = {8'h00, rxh_h0};
          end
        end
        OFS_CHANNEL_CONFIG: rdata_next = {12'h000, cfg_reg};
        OFS_INTERRUPT_STATUS_ONE: begin
          rdata_next[STAT_UNDERRUN_BIT] = underrun_reg;
          rdata_next[STAT_OVERFLOW_BIT] = overflow_reg;
          rdata_next[STAT_FRAME_LOST_BIT] = lost_reg;
          rdata_next[STAT_END_PENDING_BIT] = end_pend_reg;
          rdata_next[STAT_TX_BLOCKED_BIT] = blocked_reg;
        end
        OFS_FILL_LEVEL: begin
          rdata_next[CNT_W-1:0] = txh_cnt;
          rdata_next[LEVEL_RX_LSB +: CNT_W] = rxh_cnt;
        end
        default: rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      cfg_reg <= CFG_RESET;
      blocked_reg <= 1'b0;
      underrun_reg <= 1'b0;
      overflow_reg <= 1'b0;
      lost_reg <= 1'b0;
      lost_pulse_reg <= 1'b0;
      end_pend_reg <= 1'b0;
      stored_reg <= 1'b0;
      rx_state_reg <= RX_STORE;
      rdata_reg <= '0;
      dma_rdata_reg <= '0;
    end else if (ce_in) begin
      cfg_reg <= cfg_next;
      blocked_reg <= blocked_next;
      underrun_reg <= underrun_next;
      overflow_reg <= overflow_next;
      lost_reg <= lost_next;
      lost_pulse_reg <= lost_pulse_next;
      end_pend_reg <= end_pend_next;
      stored_reg <= stored_next; // flush leaves the open frame open
      rx_state_reg <= rx_state_next;
      rdata_reg <= rdata_next;
      dma_rdata_reg <= dma_rdata_next;
    end
  end

  // checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_frame_close;
    rx_end_in || rx_abort_in;
  endsequence

  property p_tx_refuse_blocked;
    ce_in && blocked_reg |=> txh_cnt <= $past(txh_cnt);
  endproperty
  a_tx_refuse_blocked: assert property (p_tx_refuse_blocked) else $error("write taken while blocked");

  property p_tx_no_pass_blocked;
    ce_in && blocked_reg |=> txs_cnt == $past(txs_cnt);
  endproperty
  a_tx_no_pass_blocked: assert property (p_tx_no_pass_blocked) else $error("byte passed while blocked");

  property p_release_on_read;
    ce_in && stat_rd && !transmit_underrun_in |=> !blocked_reg;
  endproperty
  a_release_on_read: assert property (p_release_on_read) else $error("status read did not release");

  property p_write_powered_down;
    ce_in && cpu_wr_tx && !reg_word_in && !power_up && !blocked_reg && txh_cnt < CNT_W'(POOL_DEPTH)
      |=> txh_cnt == $past(txh_cnt) + CNT_W'(1);
  endproperty
  a_write_powered_down: assert property (p_write_powered_down) else $error("write lost while powered down");

  property p_no_move_powered_down;
    ce_in && !power_up |=> txs_cnt <= $past(txs_cnt);
  endproperty
  a_no_move_powered_down: assert property (p_no_move_powered_down) else $error("shadow filled while down");

  property p_tx_start;
    txs_cnt != '0 && tx_enable_in && !blocked_reg |-> tx_valid_out;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("transmission did not start");

  property p_threshold;
    rxh_cnt >= threshold |-> rx_data_req_out;
  endproperty
  a_threshold: assert property (p_threshold) else $error("threshold reached without request");

  property p_overflow;
    ce_in && rx_state_reg == RX_STORE && rx_valid_in && !rx_space |=> rx_state_reg == RX_DROP && overflow_reg;
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow not flagged");

  property p_drop_holds;
    ce_in && rx_state_reg == RX_DROP && !(rx_end_in || rx_abort_in) |=> rx_state_reg == RX_DROP;
  endproperty
  a_drop_holds: assert property (p_drop_holds) else $error("resumed inside a frame");

  property p_frame_lost;
    ce_in && rx_state_reg == RX_DROP && !stored_reg ##0 s_frame_close |=> receive_frame_lost_out;
  endproperty
  a_frame_lost: assert property (p_frame_lost) else $error("lost frame not reported");

  property p_flush;
    ce_in && flush |=> rxh_cnt == '0 && rxs_cnt == '0 && !end_pend_reg;
  endproperty
  a_flush: assert property (p_flush) else $error("flush left receive data");

  property p_flush_keeps_frame;
    ce_in && flush && !rx_valid_in && !rx_end_in && !rx_abort_in |=> stored_reg == $past(stored_reg);
  endproperty
  a_flush_keeps_frame: assert property (p_flush_keeps_frame) else $error("flush closed the open frame");
endmodule : sccfp_top

//--- sim/sccfp_dma_model.sv
module sccfp_dma_model
  import sccfp_pkg::*;
(
  input wire logic mclk_in,
  input wire logic tx_req_in,
  input wire logic rx_req_in,
  input wire logic [7:0] rx_data_in,
  output logic tx_wr_out,
  output logic [7:0] tx_data_out,
  output logic rx_rd_out
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    tx_wr_out = 1'b0;
    tx_data_out = 8'h5A;
    rx_rd_out = 1'b0;
  end

  // sampled just after the edge so the request level has settled
  task automatic wait_req(input logic rx, output logic ok);
    ok = 1'b0;
    for (int n = 0; n < 200 && !ok; n++) begin
      @(posedge mclk_in);
      #1;
      ok = rx ? (rx_req_in === 1'b1) : (tx_req_in === 1'b1);
    end
  endtask : wait_req

  task automatic wr(input logic [7:0] b, output logic ok);
    wait_req(1'b0, ok);
    if (ok) begin
      tx_wr_out <= 1'b1;
      tx_data_out <= b;
      @(posedge mclk_in);
      tx_wr_out <= 1'b0;
      // released bus never keeps the old byte
      tx_data_out <= ~b;
    end
  endtask : wr

  task automatic rd(output logic [7:0] b, output logic ok);
    b = 8'h00;
    wait_req(1'b1, ok);
    if (ok) begin
      rx_rd_out <= 1'b1;
      @(posedge mclk_in);
      rx_rd_out <= 1'b0;
      #1;
      b = rx_data_in;
    end
  endtask : rd
endmodule : sccfp_dma_model

//--- sim/tb_top.sv
module tb_top;
  import sccfp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic mclk_in = 1'b0, sys_rst_in = 1'b1, ce_in = 1'b1;
  logic [ADDR_W-1:0] reg_addr_in = '0;
  logic [DATA_W-1:0] reg_wdata_in = '0, reg_rdata_out;
  logic reg_wr_in = 1'b0, reg_rd_in = 1'b0, reg_word_in = 1'b0;
  logic dma_tx_wr_in, dma_tx_req_out, dma_rx_rd_in, dma_rx_req_out;
  logic [7:0] dma_tx_data_in, dma_rx_data_out, tx_byte_out, rx_byte_in = 8'h00;
  logic tx_clk_ok_in = 1'b0, tx_enable_in = 1'b1, tx_take_in = 1'b0, tx_valid_out;
  logic transmit_underrun_in = 1'b0, tx_blocked_out, rx_valid_in = 1'b0, rx_end_in = 1'b0;
  logic rx_abort_in = 1'b0, rx_data_req_out, receive_frame_lost_out;
  int failures = 0, n_compared = 0, lost_cnt = 0;
  logic [7:0] b;
  logic ok;

  initial forever #2.5 mclk_in = ~mclk_in;

  sccfp_top DUT (.mclk_in, .sys_rst_in, .ce_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_word_in, .reg_rdata_out, .dma_tx_wr_in, .dma_tx_data_in, .dma_tx_req_out, .dma_rx_rd_in,
    .dma_rx_data_out, .dma_rx_req_out, .tx_clk_ok_in, .tx_enable_in, .tx_take_in, .tx_valid_out,
    .tx_byte_out, .transmit_underrun_in, .tx_blocked_out, .rx_valid_in, .rx_end_in, .rx_abort_in,
    .rx_byte_in, .rx_data_req_out, .receive_frame_lost_out);

  sccfp_dma_model dma (.mclk_in, .tx_req_in(dma_tx_req_out), .rx_req_in(dma_rx_req_out),
    .rx_data_in(dma_rx_data_out), .tx_wr_out(dma_tx_wr_in), .tx_data_out(dma_tx_data_in),
    .rx_rd_out(dma_rx_rd_in));

  always @(posedge mclk_in) begin
    if (!sys_rst_in && receive_frame_lost_out === 1'b1) begin
      lost_cnt <= lost_cnt + 1;
    end
  end

  task automatic stop_test();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic give_up();
    failures++;
    stop_test();
  endtask : give_up

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask : cyc

  task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic w);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_word_in <= w;
    reg_wr_in <= 1'b1;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rdc(input string what, input logic [3:0] a, input logic w, input logic [15:0] exp);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_word_in <= w;
    reg_rd_in <= 1'b1;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    #1;
    chk(what, exp, reg_rdata_out);
  endtask : rdc

  task automatic rx(input logic v, input logic e, input logic [7:0] d);
    @(posedge mclk_in);
    rx_valid_in <= v;
    rx_end_in <= e;
    rx_byte_in <= d;
    @(posedge mclk_in);
    rx_valid_in <= 1'b0;
    rx_end_in <= 1'b0;
    rx_byte_in <= ~d;
  endtask : rx

  task automatic tk(input logic [7:0] exp);
    int n;
    // step off the edge so a pop launched there has settled
    #1;
    n = 0;
    while (tx_valid_out !== 1'b1) begin
      cyc(1);
      n++;
      if (n > 20) give_up();
    end
    chk("tx byte", 16'(exp), 16'(tx_byte_out));
    @(posedge mclk_in);
    tx_take_in <= 1'b1;
    @(posedge mclk_in);
    tx_take_in <= 1'b0;
  endtask : tk

  initial begin
    repeat (3) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    rdc("level", OFS_FILL_LEVEL, 1'b0, 16'h0000);
    wr(OFS_TRANSMIT_QUEUE, 16'h00AB, 1'b0);
    wr(OFS_CHANNEL_CONFIG, 16'h000D, 1'b0);
    cyc(4);
    rdc("tx level", OFS_FILL_LEVEL, 1'b0, 16'h0001);
    tx_clk_ok_in <= 1'b1;
    tx_enable_in <= 1'b0;
    cyc(4);
    chk("tx valid", 16'h0000, 16'(tx_valid_out));
    tx_enable_in <= 1'b1;
    tk(8'hAB);
    wr(OFS_CHANNEL_CONFIG, 16'h000F, 1'b0);
    wr(OFS_TRANSMIT_QUEUE, 16'h1234, 1'b1);
    tk(8'h12);
    tk(8'h34);
    tx_enable_in <= 1'b0;
    wr(OFS_TRANSMIT_QUEUE, 16'h0066, 1'b0);
    cyc(4);
    transmit_underrun_in <= 1'b1;
    cyc(1);
    transmit_underrun_in <= 1'b0;
    tx_enable_in <= 1'b1;
    cyc(2);
    chk("blocked", 16'h0001, 16'(tx_blocked_out));
    chk("tx valid blocked", 16'h0000, 16'(tx_valid_out));
    chk("dma tx req", 16'h0000, 16'(dma_tx_req_out));
    wr(OFS_TRANSMIT_QUEUE, 16'h0055, 1'b0);
    rdc("level blocked", OFS_FILL_LEVEL, 1'b0, 16'h0000);
    rdc("status", OFS_INTERRUPT_STATUS_ONE, 1'b0, 16'h0011);
    tk(8'h66);
    dma.wr(8'h5A, ok);
    if (!ok) give_up();
    tk(8'h5A);
    rdc("status cleared", OFS_INTERRUPT_STATUS_ONE, 1'b0, 16'h0000);
    wr(OFS_CHANNEL_CONFIG, 16'h0001, 1'b0);
    for (int i = 1; i < 4; i++) rx(1'b1, 1'b0, 8'(i));
    cyc(4);
    chk("rx req low", 16'h0000, 16'(rx_data_req_out));
    rx(1'b1, 1'b0, 8'h04);
    cyc(3);
    chk("rx req high", 16'h0001, 16'(rx_data_req_out));
    rdc("word little", OFS_RECEIVE_QUEUE, 1'b1, 16'h0201);
    wr(OFS_CHANNEL_CONFIG, 16'h0003, 1'b0);
    rdc("word big", OFS_RECEIVE_QUEUE, 1'b1, 16'h0304);
    wr(OFS_CHANNEL_CONFIG, 16'h000D, 1'b0);
    for (int i = 0; i < 64; i++) begin
      if (i == 31 || i == 32) begin
        cyc(4);
        chk("rx req at 32", 16'(i == 32), 16'(rx_data_req_out));
      end
      rx(1'b1, 1'b0, 8'(i));
    end
    cyc(4);
    rdc("rx level full", OFS_FILL_LEVEL, 1'b0, 16'h2000);
    rx(1'b1, 1'b0, 8'hEE);
    cyc(2);
    rdc("overflow", OFS_INTERRUPT_STATUS_ONE, 1'b0, 16'h0002);
    rdc("head 0", OFS_RECEIVE_QUEUE, 1'b0, 16'h0000);
    rdc("head 1", OFS_RECEIVE_QUEUE, 1'b0, 16'h0001);
    cyc(4);
    rx(1'b1, 1'b0, 8'hEF);
    rx(1'b0, 1'b1, 8'h00);
    rx(1'b1, 1'b0, 8'h77);
    cyc(4);
    for (int k = 0; k < 64; k++) begin
      dma.rd(b, ok);
      if (!ok) give_up();
      chk("drain", (k < 62) ? 16'(k + 2) : ((k == 62) ? 16'h0020 : 16'h0077), 16'(b));
    end
    for (int i = 0; i < 63; i++) rx(1'b1, 1'b0, 8'(i));
    rx(1'b0, 1'b1, 8'h01);
    cyc(4);
    rx(1'b1, 1'b0, 8'hEE);
    cyc(2);
    rdc("head lost", OFS_RECEIVE_QUEUE, 1'b0, 16'h0000);
    cyc(4);
    rx(1'b0, 1'b1, 8'h00);
    cyc(3);
    chk("frame lost", 16'h0001, 16'(lost_cnt));
    wr(OFS_COMMAND, 16'h0001, 1'b0);
    cyc(1);
    rdc("level flushed", OFS_FILL_LEVEL, 1'b0, 16'h0000);
    chk("dma rx req", 16'h0000, 16'(dma_rx_req_out));
    rdc("status flushed", OFS_INTERRUPT_STATUS_ONE, 1'b0, 16'h0006);
    wr(4'hF, 16'hFFFF, 1'b0);
    rdc("unmapped", 4'hF, 1'b0, 16'h0000);
    // flush inside an open frame: its end still closes it as a normal frame
    rx(1'b1, 1'b0, 8'h42);
    wr(OFS_COMMAND, 16'h0001, 1'b0);
    rx(1'b0, 1'b1, 8'h99);
    cyc(3);
    chk("end pending", 16'h0001, 16'(rx_data_req_out));
    rdc("appended end", OFS_RECEIVE_QUEUE, 1'b0, 16'h0099);
    // abort outside overflow keeps the stored byte and adds nothing
    rx(1'b1, 1'b0, 8'h42);
    rx_abort_in <= 1'b1;
    cyc(1);
    rx_abort_in <= 1'b0;
    cyc(3);
    rdc("abort level", OFS_FILL_LEVEL, 1'b0, 16'h0100);
    stop_test();
  end
endmodule : tb_top
